//--- rtl/lpdpi_buf.sv
/*
  Small valid/ready buffer whose width and depth are parameters.
  Assumes one clock; flush empties it at once and wins over a push.
*/
`default_nettype none

module lpdpi_buf #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 2
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_flush,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

  // Storage entries and pointers.
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0] wp_q, wp_d, rp_q, rp_d;
  // Fill level; full and empty come straight from it, so they never lie.
  logic [CW-1:0] cnt_q, cnt_d;
  logic push, pop;

  assign o_ready = cnt_q != CW'(DEPTH);
  assign o_valid = cnt_q != '0;
  assign o_data = mem_q[rp_q];
  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;

  // Next pointer and fill values.
  always_comb begin
    wp_d = wp_q;
    rp_d = rp_q;
    cnt_d = cnt_q;
    if (push) begin
      wp_d = (wp_q == LAST) ? '0 : wp_q + PW'(1);
    end
    if (pop) begin
      rp_d = (rp_q == LAST) ? '0 : rp_q + PW'(1);
    end
    case ({push, pop})
      2'b10: cnt_d = cnt_q + CW'(1);
      2'b01: cnt_d = cnt_q - CW'(1);
      default: cnt_d = cnt_q;
    endcase
    // A flush drops everything, including a word offered in the same cycle.
    if (i_flush) begin
      wp_d = '0;
      rp_d = '0;
      cnt_d = '0;
    end
  end

  // Pointer registers.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
    end
  end

  // Entry storage; needs no reset because the fill level guards it.
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_q[wp_q] <= i_data;
    end
  end

endmodule

`default_nettype wire

//--- rtl/lpdpi_pkg.sv
/*
  Shared constants, types and helper functions for the low-power DDR pin-side
  command and data interface model.
  Assumes a single system clock domain; every pin is synchronised before use.
*/
// Behaviour
// - Address and control captured at rising crossing only.
// - Data moves on both clock crossings.
// - Activate opens given row in chosen bank.
// - Read/write take start column and precharge flag.
// - Address bit ten requests auto precharge.
// - Mode set loads opcode from address pins.
// - Bank select bits pick the target bank.
// - Commands decoded only with chip select low.
// - Command from select and three strobes.
// - Masked write bytes are not stored.
// - Byte mask sampled on every strobe edge.
// - One mask per eight-bit data lane.
// - Data bus is sixteen or thirty-two bits; this model fixes DQ_WIDTH at 16.
// - Per-lane strobe, edge-aligned out, captures writes; here the lane 0 strobe captures writes for all lanes.
// - Clock enable low stops internal activity; here a running read still fetches ahead into the read buffer.
`default_nettype none

package lpdpi_pkg;

  // Data bus width; the wide part uses 32.
  localparam int DQ_WIDTH = 16;
  // One strobe and one mask per byte lane.
  localparam int LANES = DQ_WIDTH / 8;
  localparam int ADDR_WIDTH = 12;
  localparam int BANK_WIDTH = 2;
  localparam int NUM_BANKS = 4;
  // Width of beat counters; holds the longest burst.
  localparam int BEAT_W = 5;
  localparam int AUTO_PRECHARGE_BIT = 10;
  // Mode register fields.
  localparam int BL_LSB = 0;
  localparam int BL_W = 3;
  localparam int CL_LSB = 4;
  localparam int CL_W = 3;
  // Reset mode: burst of four, latency three.
  localparam logic [ADDR_WIDTH-1:0] MODE_RST = 12'h032;
  // Bank code that addresses the main mode register.
  localparam logic [BANK_WIDTH-1:0] MRS_BANK = 2'h0;
  // Burst length codes and their beat counts.
  localparam logic [BL_W-1:0] BL4_CODE = 3'h2;
  localparam logic [BL_W-1:0] BL8_CODE = 3'h3;
  localparam logic [BL_W-1:0] BL16_CODE = 3'h4;
  localparam logic [BEAT_W-1:0] BL2_BEATS = 5'h02;
  localparam logic [BEAT_W-1:0] BL4_BEATS = 5'h04;
  localparam logic [BEAT_W-1:0] BL8_BEATS = 5'h08;
  localparam logic [BEAT_W-1:0] BL16_BEATS = 5'h10;
  // Depth of the read data buffer.
  localparam int BUF_DEPTH = 2;

  // Command code is {row strobe, column strobe, write enable}, all low active.
  typedef enum logic [2:0] {
    CMD_MRS = 3'h0,
    CMD_REF = 3'h1,
    CMD_PRE = 3'h2,
    CMD_ACT = 3'h3,
    CMD_WR = 3'h4,
    CMD_RD = 3'h5,
    CMD_BST = 3'h6,
    CMD_NOP = 3'h7
  } lpdpi_cmd_t;

  // Access state of the data path.
  typedef enum logic [1:0] {ST_IDLE, ST_RD_WAIT, ST_RD_BURST, ST_WR_BURST} lpdpi_state_t;

  // All input pins, carried together through the synchroniser.
  typedef struct packed {
    logic ck;
    logic ck_n;
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [BANK_WIDTH-1:0] bank_select_bits;
    logic [ADDR_WIDTH-1:0] addr;
    logic [DQ_WIDTH-1:0] dq;
    logic [LANES-1:0] dqs;
    logic [LANES-1:0] write_byte_mask;
  } lpdpi_pins_t;

  // Beats of a burst from the mode field; unknown codes fall back to two.
  function automatic logic [BEAT_W-1:0] burst_beats(input logic [BL_W-1:0] code);
    case (code)
      BL4_CODE: return BL4_BEATS;
      BL8_CODE: return BL8_BEATS;
      BL16_CODE: return BL16_BEATS;
      default: return BL2_BEATS;
    endcase
  endfunction

  // Column of beat n: sequential order, wrapping inside the aligned burst block.
  function automatic logic [ADDR_WIDTH-1:0] burst_col(input logic [ADDR_WIDTH-1:0] base,
                                                      input logic [BEAT_W-1:0] n,
                                                      input logic [BEAT_W-1:0] len);
    logic [ADDR_WIDTH-1:0] m;
    m = {{(ADDR_WIDTH-BEAT_W){1'b0}}, len - 5'h01};
    return (base & ~m) | ((base + {{(ADDR_WIDTH-BEAT_W){1'b0}}, n}) & m);
  endfunction

endpackage

`default_nettype wire

//--- rtl/lpdpi_top.sv
/*
  Memory-side model of a low-power DDR command, address and data pin interface:
  command decode, bank rows, mode register, masked writes and buffered reads.
  Assumes the controller clock and strobes are slow against I_MCLK (several
  system cycles per half period), and that two-way pins are resolved outside.
*/
`default_nettype none

module lpdpi_top
  import lpdpi_pkg::*;
#(
  parameter int ROW_IDX_BITS = 2,
  parameter int COL_IDX_BITS = 4
) (
  input wire logic I_MCLK,
  input wire logic I_RESET,
  input wire logic I_CK,
  input wire logic I_CK_N,
  input wire logic I_CKE,
  input wire logic I_CS_N,
  input wire logic I_RAS_N,
  input wire logic I_CAS_N,
  input wire logic I_WE_N,
  input wire logic [BANK_WIDTH-1:0] I_BANK_SELECT_BITS,
  input wire logic [ADDR_WIDTH-1:0] I_ADDR,
  input wire logic [DQ_WIDTH-1:0] I_DQ,
  output logic [DQ_WIDTH-1:0] O_DQ,
  output logic O_DQ_OE,
  input wire logic [LANES-1:0] I_DQS,
  output logic [LANES-1:0] O_DQS,
  output logic [LANES-1:0] O_DQS_OE,
  input wire logic [LANES-1:0] I_WRITE_BYTE_MASK,
  output logic O_POWER_DOWN,
  output logic [NUM_BANKS-1:0] O_BANK_OPEN
);

  // Storage index is {bank, low row bits, low column bits}.
  localparam int IDX_W = BANK_WIDTH + ROW_IDX_BITS + COL_IDX_BITS;
  localparam int MEM_DEPTH = 1 << IDX_W;

  // Pin vector and its three synchroniser stages.
  lpdpi_pins_t pins_in, s1_q, s2_q, s3_q;
  // Filtered levels {strobe lane 0, clock enable, clock low leg, clock high leg}.
  logic [3:0] lvl_q, lvl_d;
  logic [3:0] raw2, raw3;
  // Crossing and strobe events, already gated by clock enable.
  logic ck_rise, ck_fall, crossing, dqs_edge;
  // Decoded command of this rising crossing.
  lpdpi_cmd_t cmd;
  logic cmd_ok;

  // Control state.
  lpdpi_state_t st_q, st_d;
  logic [NUM_BANKS-1:0] bank_open_q, bank_open_d;
  logic [ADDR_WIDTH-1:0] bank_row_q [NUM_BANKS];
  logic [ADDR_WIDTH-1:0] bank_row_d [NUM_BANKS];
  logic [ADDR_WIDTH-1:0] mode_q, mode_d;
  logic [BANK_WIDTH-1:0] cur_bank_q, cur_bank_d;
  logic [ADDR_WIDTH-1:0] col_q, col_d;
  logic ap_q, ap_d;
  // Counts latency clocks on reads and beats on writes.
  logic [BEAT_W-1:0] cnt_q, cnt_d;
  // Words fetched into the buffer and words sent out.
  logic [BEAT_W-1:0] push_q, push_d, pop_q, pop_d;
  logic [DQ_WIDTH-1:0] dq_q, dq_d;
  logic dqs_q, dqs_d, oe_q, oe_d, pd_q, pd_d;
  logic close_cur, flush;

  // Burst figures from the mode register.
  logic [BEAT_W-1:0] bl, cl;
  logic go;
  // Storage addressing and buffer handshake.
  logic [IDX_W-1:0] wr_idx, rd_idx;
  logic [ADDR_WIDTH-1:0] cur_row, wr_col, rd_col;
  logic wr_beat;
  logic [DQ_WIDTH-1:0] rd_word, pop_data;
  logic push_valid, push_ready, pop_valid, pop_ready;

  assign pins_in = '{ck: I_CK, ck_n: I_CK_N, cke: I_CKE, cs_n: I_CS_N, ras_n: I_RAS_N,
                     cas_n: I_CAS_N, we_n: I_WE_N, bank_select_bits: I_BANK_SELECT_BITS,
                     addr: I_ADDR, dq: I_DQ, dqs: I_DQS, write_byte_mask: I_WRITE_BYTE_MASK};

  // Three-stage synchroniser; the first stage feeds only the second.
  always_ff @(posedge I_MCLK) begin
    if (I_RESET) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      lvl_q <= '0;
    end else begin
      s1_q <= pins_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= lvl_d;
    end
  end

  assign raw2 = {s2_q.dqs[0], s2_q.cke, s2_q.ck_n, s2_q.ck};
  assign raw3 = {s3_q.dqs[0], s3_q.cke, s3_q.ck_n, s3_q.ck};

  // A level only moves once stages two and three agree, which rejects glitches.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      lvl_d[i] = (raw2[i] == raw3[i]) ? raw3[i] : lvl_q[i];
    end
  end

  // rising crossing detect.
  // The crossing needs both legs: true clock high and complement low.
  // Clock enable must already have been high, so no crossing is invented while the filter refills after reset.
  assign ck_rise = lvl_d[0] && !lvl_d[1] && !(lvl_q[0] && !lvl_q[1]) && lvl_d[2] && lvl_q[2];
  assign ck_fall = !lvl_d[0] && lvl_d[1] && !(!lvl_q[0] && lvl_q[1]) && lvl_d[2] && lvl_q[2];
  assign crossing = ck_rise || ck_fall;
  // strobe edges capture writes.
  // Lane 0 strobe paces all lanes; lanes are assumed to be sent together.
  assign dqs_edge = (lvl_d[3] != lvl_q[3]) && lvl_d[2];

  assign cmd = lpdpi_cmd_t'({s3_q.ras_n, s3_q.cas_n, s3_q.we_n});
  assign cmd_ok = ck_rise && !s3_q.cs_n;

  assign bl = burst_beats(mode_q[BL_LSB +: BL_W]);
  assign cl = {{(BEAT_W-CL_W){1'b0}}, mode_q[CL_LSB +: CL_W]};
  assign cur_row = bank_row_q[cur_bank_q];

  // start column selects location.
  // A function result cannot be sliced directly, so the full columns are named first.
  assign wr_col = burst_col(col_q, cnt_q, bl);
  assign rd_col = burst_col(col_q, push_q, bl);
  assign wr_idx = {cur_bank_q, cur_row[ROW_IDX_BITS-1:0], wr_col[COL_IDX_BITS-1:0]};
  assign rd_idx = {cur_bank_q, cur_row[ROW_IDX_BITS-1:0], rd_col[COL_IDX_BITS-1:0]};
  // mask taken on every strobe edge.
  assign wr_beat = (st_q == ST_WR_BURST) && dqs_edge;

  // Reads are fetched ahead while the buffer has room; a full buffer stalls the fetch.
  assign push_valid = ((st_q == ST_RD_WAIT) || (st_q == ST_RD_BURST)) && (push_q < bl);
  // The first beat leaves at the rising crossing that ends the latency.
  assign go = (st_q == ST_RD_WAIT) && ck_rise && (cnt_q == cl - 5'h01);
  assign pop_ready = crossing && (pop_q < bl) && ((st_q == ST_RD_BURST) || go);

  // Per-lane storage, one byte array per lane.
  for (genvar l = 0; l < LANES; l++) begin : g_lane
    logic [7:0] mem_q [MEM_DEPTH];
    logic [7:0] old_q;
    logic [IDX_W-1:0] idx_q;

    always_ff @(posedge I_MCLK) begin
      if (wr_beat && !s3_q.write_byte_mask[l]) begin
        mem_q[wr_idx] <= s3_q.dq[l*8 +: 8];
      end
    end

    assign rd_word[l*8 +: 8] = mem_q[rd_idx];

    // Snapshot of the addressed byte, read only by the check below.
    always_ff @(posedge I_MCLK) begin
      old_q <= mem_q[wr_idx];
      idx_q <= wr_idx;
    end

    a_mask_keeps_byte: assert property (@(posedge I_MCLK) disable iff (I_RESET)
      (wr_beat && s3_q.write_byte_mask[l]) |=> mem_q[idx_q] == old_q)
      else $error("masked write byte was stored");
  end

  // Read data buffer between storage fetch and the pins.
  lpdpi_buf #(
    .WIDTH(DQ_WIDTH),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .i_clk(I_MCLK),
    .i_reset(I_RESET),
    .i_flush(flush),
    .i_valid(push_valid),
    .o_ready(push_ready),
    .i_data(rd_word),
    .o_valid(pop_valid),
    .i_ready(pop_ready),
    .o_data(pop_data)
  );

  // Next values for the access state, bank table and output pins.
  always_comb begin
    st_d = st_q;
    bank_open_d = bank_open_q;
    bank_row_d = bank_row_q;
    mode_d = mode_q;
    cur_bank_d = cur_bank_q;
    col_d = col_q;
    ap_d = ap_q;
    cnt_d = cnt_q;
    push_d = push_q;
    pop_d = pop_q;
    dq_d = dq_q;
    dqs_d = dqs_q;
    oe_d = oe_q;
    close_cur = 1'b0;
    flush = 1'b0;
    pd_d = !lvl_d[2];
    if (push_valid && push_ready) begin
      push_d = push_q + 5'h01;
    end
    case (st_q)
      ST_RD_WAIT: begin
        if (ck_rise) begin
          cnt_d = cnt_q + 5'h01;
        end
      end
      ST_RD_BURST: begin
        // One crossing after the last beat the bus is released.
        if (crossing && (pop_q == bl)) begin
          oe_d = 1'b0;
          st_d = ST_IDLE;
          close_cur = ap_q;
        end
      end
      ST_WR_BURST: begin
        if (wr_beat) begin
          cnt_d = cnt_q + 5'h01;
          if (cnt_q == bl - 5'h01) begin
            st_d = ST_IDLE;
            close_cur = ap_q;
          end
        end
      end
      default: begin
      end
    endcase
    if (pop_ready && pop_valid) begin
      dq_d = pop_data;
      dqs_d = ck_rise;
      oe_d = 1'b1;
      pop_d = pop_q + 5'h01;
      st_d = ST_RD_BURST;
    end
    if (close_cur) begin
      bank_open_d[cur_bank_q] = 1'b0;
    end
    // A new command overrides whatever the running burst asked for.
    if (cmd_ok) begin
      case (cmd)
        CMD_ACT: begin
          bank_open_d[s3_q.bank_select_bits] = 1'b1;
          bank_row_d[s3_q.bank_select_bits] = s3_q.addr;
        end
        CMD_PRE: begin
          // Address bit ten widens a precharge to all banks.
          if (s3_q.addr[AUTO_PRECHARGE_BIT]) begin
            bank_open_d = '0;
          end else begin
            bank_open_d[s3_q.bank_select_bits] = 1'b0;
          end
        end
        CMD_RD, CMD_WR: begin
          cur_bank_d = s3_q.bank_select_bits;
          col_d = s3_q.addr;
          ap_d = s3_q.addr[AUTO_PRECHARGE_BIT];
          cnt_d = '0;
          push_d = '0;
          pop_d = '0;
          oe_d = 1'b0;
          flush = 1'b1;
          st_d = (cmd == CMD_RD) ? ST_RD_WAIT : ST_WR_BURST;
        end
        CMD_BST: begin
          // Terminate the burst without closing the row.
          st_d = ST_IDLE;
          oe_d = 1'b0;
          flush = 1'b1;
        end
        CMD_MRS: begin
          if (s3_q.bank_select_bits == MRS_BANK) begin
            mode_d = s3_q.addr;
          end
        end
        default: begin
          // Refresh and no-operation leave this interface unchanged.
        end
      endcase
    end
  end

  // Registers of the access state; every control bit has a reset value.
  always_ff @(posedge I_MCLK) begin
    if (I_RESET) begin
      st_q <= ST_IDLE;
      bank_open_q <= '0;
      mode_q <= MODE_RST;
      cur_bank_q <= '0;
      col_q <= '0;
      ap_q <= 1'b0;
      cnt_q <= '0;
      push_q <= '0;
      pop_q <= '0;
      dq_q <= '0;
      dqs_q <= 1'b0;
      oe_q <= 1'b0;
      pd_q <= 1'b1;
      for (int b = 0; b < NUM_BANKS; b++) begin
        bank_row_q[b] <= '0;
      end
    end else begin
      st_q <= st_d;
      bank_open_q <= bank_open_d;
      mode_q <= mode_d;
      cur_bank_q <= cur_bank_d;
      col_q <= col_d;
      ap_q <= ap_d;
      cnt_q <= cnt_d;
      push_q <= push_d;
      pop_q <= pop_d;
      dq_q <= dq_d;
      dqs_q <= dqs_d;
      oe_q <= oe_d;
      pd_q <= pd_d;
      bank_row_q <= bank_row_d;
    end
  end

  assign O_DQ = dq_q;
  assign O_DQ_OE = oe_q;
  assign O_DQS = {LANES{dqs_q}};
  assign O_DQS_OE = {LANES{oe_q}};
  assign O_POWER_DOWN = pd_q;
  assign O_BANK_OPEN = bank_open_q;

  default clocking @(posedge I_MCLK);
  endclocking
  default disable iff (I_RESET);

  sequence s_rd_cmd;
    cmd_ok && (cmd == CMD_RD);
  endsequence

  sequence s_leave_idle;
    (st_q == ST_IDLE) ##1 (st_q != ST_IDLE);
  endsequence

  a_capture_rise_only: assert property (s_leave_idle |-> $past(ck_rise))
    else $error("access started away from a rising crossing");
  a_deselect_no_effect: assert property ((ck_rise && s3_q.cs_n && (st_q == ST_IDLE))
    |=> (st_q == ST_IDLE) && $stable(bank_open_q))
    else $error("deselected cycle changed state");
  a_act_opens_row: assert property ((cmd_ok && (cmd == CMD_ACT))
    |=> bank_open_q[$past(s3_q.bank_select_bits)]
        && (bank_row_q[$past(s3_q.bank_select_bits)] == $past(s3_q.addr)))
    else $error("activate did not open the row");
  a_read_takes_col: assert property (s_rd_cmd |=> (st_q == ST_RD_WAIT)
    && (col_q == $past(s3_q.addr)) && (ap_q == $past(s3_q.addr[AUTO_PRECHARGE_BIT])))
    else $error("read did not take column and flag");
  a_mrs_loads_op: assert property ((cmd_ok && (cmd == CMD_MRS) && (s3_q.bank_select_bits == MRS_BANK))
    |=> mode_q == $past(s3_q.addr))
    else $error("mode set did not load opcode");
  a_ap_closes_bank: assert property ((wr_beat && (cnt_q == bl - 5'h01) && ap_q && !cmd_ok)
    |=> !bank_open_q[$past(cur_bank_q)] && (st_q == ST_IDLE))
    else $error("auto precharge left the bank open");
  a_read_beat_out: assert property ((pop_ready && pop_valid && !cmd_ok)
    |=> O_DQ_OE && (O_DQS[0] == $past(ck_rise)) && (O_DQ == $past(pop_data)))
    else $error("read beat not driven at its crossing");
  a_cke_low_frozen: assert property ((!lvl_q[2] && !lvl_d[2] && (st_q == ST_IDLE))
    |=> (st_q == ST_IDLE) && $stable(mode_q) && O_POWER_DOWN)
    else $error("activity while clock enable low");

endmodule

`default_nettype wire

//--- verif/lpdpi_ctl_model.sv
/*
  Behavioural memory controller that drives the pins of the memory model.
  Assumes the bench resolves the two-way pins and calls its tasks one at a time.
*/
`default_nettype none

module lpdpi_ctl_model
  import lpdpi_pkg::*;
(
  output logic o_ck,
  output logic o_ck_n,
  output logic o_cke,
  output logic o_cs_n,
  output logic [2:0] o_cmd,
  output logic [BANK_WIDTH-1:0] o_bank,
  output logic [ADDR_WIDTH-1:0] o_addr,
  output logic [DQ_WIDTH-1:0] o_dq,
  output logic [LANES-1:0] o_dqs,
  output logic [LANES-1:0] o_mask
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle pins: deselected, strobe low as its preamble wants.
  initial begin
    o_ck = 1'b0;
    o_cke = 1'b1;
    o_cs_n = 1'b1;
    o_cmd = CMD_NOP;
    o_bank = 2'h0;
    o_addr = 12'h000;
    o_dq = 16'h0000;
    o_dqs = 2'h0;
    o_mask = 2'h0;
  end

  // The memory clock runs free at a 125 ns period, so the device can pace reads.
  always #62.5 o_ck = ~o_ck;

  // the complement leg is the exact inverse of the true leg.
  always_comb o_ck_n = ~o_ck;

  // Clock enable changes only while the clock is low.
  task automatic set_cke(input logic v);
    @(negedge o_ck);
    o_cke <= v;
  endtask

  // pins held from one falling crossing to the next.
  task automatic command(input logic cs_n, input lpdpi_cmd_t cmd, input logic [1:0] bank, input logic [11:0] addr);
    @(negedge o_ck);
    o_cs_n <= cs_n;
    o_cmd <= cmd;
    o_bank <= bank;
    o_addr <= addr;
    @(negedge o_ck);
    o_cs_n <= 1'b1;
    o_cmd <= CMD_NOP;
    o_addr <= ~addr;
  endtask

  // one beat per strobe edge, data and mask centred on the edge.
  task automatic burst(input int beats, input logic [15:0] d[16], input logic [1:0] m[16]);
    for (int n = 0; n < beats; n++) begin
      o_dq <= d[n];
      o_mask <= m[n];
      #30;
      o_dqs <= ~o_dqs;
      #32.5;
    end
    // A released bus must not keep showing the last beat.
    o_dq <= ~o_dq;
  endtask
endmodule

`default_nettype wire

//--- verif/tb_top.sv
/*
  Self-checking bench: commands, bank state, masked writes and buffered reads.
  Assumes the controller model drives the link and read beats go through a queue.
*/
`default_nettype none

module tb_top
  import lpdpi_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic ck, ck_n, cke, cs_n, pd, oe, prev_oe, prev_dqs;
  logic [2:0] cmd;
  logic [1:0] bank, c_dqs, c_mask, dqs_o, dqs_oe, dqs_w;
  logic [11:0] addr;
  logic [15:0] c_dq, dq_o, dq_w;
  logic [3:0] bank_open;
  logic [15:0] exp_q[$];
  logic [15:0] model[16];
  logic [15:0] wd[16];
  logic [1:0] wm[16];
  int fail_count, total_checks, seed;

  always #5 mclk = ~mclk;

  // The device's enable wins on the shared data and strobe lines.
  assign dq_w = oe ? dq_o : c_dq;
  assign dqs_w = (dqs_oe & dqs_o) | (~dqs_oe & c_dqs);

  lpdpi_ctl_model u_ctl (.o_ck(ck), .o_ck_n(ck_n), .o_cke(cke), .o_cs_n(cs_n), .o_cmd(cmd), .o_bank(bank),
    .o_addr(addr), .o_dq(c_dq), .o_dqs(c_dqs), .o_mask(c_mask));

  lpdpi_top u_dut (.I_MCLK(mclk), .I_RESET(rst), .I_CK(ck), .I_CK_N(ck_n), .I_CKE(cke), .I_CS_N(cs_n),
    .I_RAS_N(cmd[2]), .I_CAS_N(cmd[1]), .I_WE_N(cmd[0]), .I_BANK_SELECT_BITS(bank), .I_ADDR(addr),
    .I_DQ(dq_w), .O_DQ(dq_o), .O_DQ_OE(oe), .I_DQS(dqs_w), .O_DQS(dqs_o), .O_DQS_OE(dqs_oe),
    .I_WRITE_BYTE_MASK(c_mask), .O_POWER_DOWN(pd), .O_BANK_OPEN(bank_open));

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check_pins(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t pins got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic check_beat(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t beat got %h exp %h", $time, got, exp);
    end
  endtask

  // Bank flags settle a few system cycles after the rising crossing or last strobe edge.
  task automatic expect_banks(input logic [3:0] e);
    repeat (3) @(posedge mclk);
    check_pins({12'h000, bank_open}, {12'h000, e});
  endtask

  // A new read beat shows as the enable rising or the strobe turning over.
  always @(negedge mclk) begin
    if (oe === 1'b1 && (prev_oe !== 1'b1 || dqs_o[0] !== prev_dqs)) begin
      if (exp_q.size() == 0) begin
        fail_count++;
        $display("[ERR] %0t extra beat %h exp none", $time, dq_o);
      end else begin
        check_beat(dq_o, exp_q.pop_front());
        check_pins({14'h0000, dqs_oe}, 16'h0003);
      end
    end
    prev_oe = oe;
    prev_dqs = dqs_o[0];
  end

  // Hang guard: a bounded count of system cycles.
  initial begin
    repeat (100000) @(posedge mclk);
    fail_count++;
    wrap_up();
  end

  initial begin
    int col;
    int bl;
    int cx;
    logic [1:0] bk;
    seed = 32'ha9103e1f;
    fail_count = 0;
    total_checks = 0;
    repeat (5) @(posedge mclk);
    check_pins({15'h0000, pd}, 16'h0001);
    rst <= 1'b0;
    repeat (20) @(posedge mclk);
    check_pins({15'h0000, pd}, 16'h0000);
    for (int b = 0; b < 4; b++) begin
      u_ctl.command(1'b0, CMD_ACT, 2'(b), 12'(b + 1));
      expect_banks(4'((1 << (b + 1)) - 1));
    end
    // Refresh, stop and no-op leave every bank alone.
    u_ctl.command(1'b0, CMD_REF, 2'h0, 12'h400);
    u_ctl.command(1'b0, CMD_BST, 2'h0, 12'h400);
    u_ctl.command(1'b0, CMD_NOP, 2'h0, 12'h400);
    expect_banks(4'hf);
    u_ctl.command(1'b1, CMD_PRE, 2'h0, 12'h400);
    expect_banks(4'hf);
    u_ctl.command(1'b0, CMD_PRE, 2'h1, 12'h000);
    expect_banks(4'hd);
    u_ctl.command(1'b0, CMD_PRE, 2'h0, 12'h400);
    expect_banks(4'h0);
    // With the enable low a command must not reach the banks.
    u_ctl.set_cke(1'b0);
    u_ctl.command(1'b0, CMD_ACT, 2'h0, 12'h000);
    expect_banks(4'h0);
    check_pins({15'h0000, pd}, 16'h0001);
    u_ctl.set_cke(1'b1);
    repeat (10) @(posedge mclk);
    for (int c = 0; c < 2; c++) begin
      bl = c ? 8 : 4;
      col = c ? 5 : 2;
      bk = c ? 2'h3 : 2'h2;
      u_ctl.command(1'b0, CMD_MRS, MRS_BANK, c ? 12'h023 : 12'h032);
      // A mode set aimed at another bank code must be dropped.
      u_ctl.command(1'b0, CMD_MRS, 2'h1, 12'h032);
      u_ctl.command(1'b0, CMD_ACT, bk, 12'h001);
      for (int p = 0; p < 2; p++) begin
        for (int n = 0; n < bl; n++) begin
          wd[n] = 16'($random(seed));
          wm[n] = p ? 2'($random(seed)) : 2'h0;
          cx = (col & ~(bl - 1)) | ((col + n) & (bl - 1));
          // a high mask bit keeps its own byte lane.
          if (!wm[n][0]) model[cx][7:0] = wd[n][7:0];
          if (!wm[n][1]) model[cx][15:8] = wd[n][15:8];
        end
        // The second pass asks for auto precharge, so the bank must close after its last beat.
        u_ctl.command(1'b0, CMD_WR, bk, 12'(col) | (p ? 12'h400 : 12'h000));
        u_ctl.burst(bl, wd, wm);
        expect_banks(p ? 4'h0 : 4'(1 << bk));
      end
      // Reopen the row that the last write closed.
      u_ctl.command(1'b0, CMD_ACT, bk, 12'h001);
      for (int n = 0; n < bl; n++) exp_q.push_back(model[(col & ~(bl - 1)) | ((col + n) & (bl - 1))]);
      u_ctl.command(1'b0, CMD_RD, bk, 12'h400 | 12'(col));
      repeat (7) @(posedge ck);
      for (int k = 0; k < 300 && exp_q.size() > 0; k++) @(posedge mclk);
      check_pins(16'(exp_q.size()), 16'h0000);
      expect_banks(4'h0);
    end
    wrap_up();
  end
endmodule

`default_nettype wire
